// >>> card_info_pkg.sv
package card_info_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;        // 100 MHz core clock
    localparam int BLOCK_GAP_NS    = 1000;      // block to block, same sector
    localparam int SHORT_GAP_NS    = 62000;     // block to block, short blocks
    localparam int BLOCK_GAP_CYC   = (BLOCK_GAP_NS / CLK_PERIOD_NS > 0) ? BLOCK_GAP_NS / CLK_PERIOD_NS : 1;
    localparam int SHORT_GAP_CYC   = (SHORT_GAP_NS / CLK_PERIOD_NS > 0) ? SHORT_GAP_NS / CLK_PERIOD_NS : 1;
    localparam int GAP_W           = 13;        // wide enough for the short-block count
    localparam logic [11:0] SHORT_BLOCK_BYTES = 12'h100;

    // ------------------------------------------------------------
    // register widths and serial lengths
    // ------------------------------------------------------------
    localparam int OPCOND_W        = 32;
    localparam int RECORD_W        = 128;
    localparam int ADDR_W          = 16;
    localparam int CNT_W           = 7;
    localparam logic [CNT_W-1:0] OPCOND_LAST = 7'h1f;   // bits left after first
    localparam logic [CNT_W-1:0] RECORD_LAST = 7'h7f;
    localparam int OPCOND_READY_BIT = 31;               // power-up-complete flag
    localparam logic [30:0] OPCOND_VOLT_RANGE = 31'h00ff8000;

    // ------------------------------------------------------------
    // address register
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_DEFAULT  = 16'h0001;
    localparam logic [ADDR_W-1:0] ADDR_BCAST    = 16'h0000;

    // ------------------------------------------------------------
    // identity record checksum
    // ------------------------------------------------------------
    localparam int ID_MSG_W        = 120;               // bits 127:8
    localparam logic [6:0] CRC7_POLY = 7'h09;           // x^7 + x^3 + 1

    // ------------------------------------------------------------
    // parameter record, fixed part (bits 127:16)
    // ------------------------------------------------------------
    localparam logic [1:0]  PAR_LAYOUT_VERSION = 2'h1;
    localparam logic [3:0]  PAR_SPEC_VERSION   = 4'h2;
    localparam logic [7:0]  PAR_ASYNC_ACCESS   = 8'h0e;
    localparam logic [7:0]  PAR_CLOCKED_ACCESS = 8'h01;
    localparam logic [7:0]  PAR_MAX_RATE       = 8'h2a;
    localparam logic [11:0] PAR_CLASSES        = 12'h0ff;
    localparam logic [3:0]  PAR_READ_BLOCK_LENGTH   = 4'h9;
    localparam logic [11:0] PAR_DEVICE_SIZE    = 12'h7a7;
    localparam logic [2:0]  PAR_RD_CUR_LOW     = 3'h5;
    localparam logic [2:0]  PAR_RD_CUR_HIGH    = 3'h4;
    localparam logic [2:0]  PAR_WR_CUR_LOW     = 3'h5;
    localparam logic [2:0]  PAR_WR_CUR_HIGH    = 3'h4;
    localparam logic [2:0]  PAR_CAP_MULT       = 3'h3;
    localparam logic [4:0]  PAR_ERASE_CLUSTER  = 5'h0f;
    localparam logic [4:0]  PAR_PROTECT_CLUSTER = 5'h01;
    localparam logic [2:0]  PAR_WRITE_SPEED    = 3'h2;
    localparam logic [3:0]  PAR_WRITE_BLOCK_LENGTH  = 4'h9;

    localparam logic [111:0] PAR_FIXED = {
        PAR_LAYOUT_VERSION, PAR_SPEC_VERSION, 2'h0,
        PAR_ASYNC_ACCESS, PAR_CLOCKED_ACCESS, PAR_MAX_RATE,
        PAR_CLASSES, PAR_READ_BLOCK_LENGTH,
        1'b1, 1'b0, 1'b0, 1'b0, 2'h0,          // partial read, no misalign, no driver stage
        PAR_DEVICE_SIZE,
        PAR_RD_CUR_LOW, PAR_RD_CUR_HIGH, PAR_WR_CUR_LOW, PAR_WR_CUR_HIGH,
        PAR_CAP_MULT, 5'h00, PAR_ERASE_CLUSTER, PAR_PROTECT_CLUSTER,
        1'b1, 2'h0, PAR_WRITE_SPEED, PAR_WRITE_BLOCK_LENGTH, 1'b0, 5'h00
    };

    // ------------------------------------------------------------
    // parameter record, user part (bits 15:0)
    // ------------------------------------------------------------
    localparam logic [15:0] USER_RESET      = 16'h0001;
    localparam logic [15:0] USER_COPY_MASK  = 16'h4000; // one-time settable
    localparam logic [15:0] USER_ERASE_MASK = 16'h13fe; // bits 12, 9:8, 7:1
    localparam logic [15:0] USER_FIXED_ONE  = 16'h0001; // bit 0 stuck at one

    // ------------------------------------------------------------
    // commands seen by the register bank
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE      = 3'b000,
        CMD_RD_OPCOND = 3'b001,
        CMD_RD_IDENT  = 3'b010,
        CMD_RD_PARAMS = 3'b011,
        CMD_SET_ADDR  = 3'b100,
        CMD_PROG_PAR  = 3'b101,
        CMD_ERASE_PAR = 3'b110,
        CMD_GO_IDLE   = 3'b111
    } cmd_t;

    typedef enum logic [0:0] {
        PH_IDLE  = 1'b0,
        PH_SHIFT = 1'b1
    } phase_t;

endpackage

// >>> id_crc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface id_crc_if;
    import card_info_pkg::*;
    logic [ID_MSG_W-1:0] message;   // identity bits 127:8
    logic [6:0]          remainder; // seven-bit checksum
    modport calc (input message, output remainder);
    modport user (output message, input remainder);
endinterface
`default_nettype wire

// >>> id_checksum.sv
`timescale 1ns/10ps
`default_nettype none
module id_checksum
    import card_info_pkg::*;
(
    // message in, checksum out
    id_crc_if.calc link
);

    // ------------------------------------------------------------
    // bitwise division by the generator, msb first
    // ------------------------------------------------------------
    // purely combinational; the message is static so depth costs nothing
    always_comb
    begin
        logic [6:0] crc;
        logic       feed;
        crc  = 7'h00;
        feed = 1'b0;
        for (int i = ID_MSG_W - 1; i >= 0; i--)
        begin
            feed = link.message[i] ^ crc[6];
            crc  = {crc[5:0], 1'b0} ^ (feed ? CRC7_POLY : 7'h00);
        end
        link.remainder = crc;
    end

endmodule
`default_nettype wire

// >>> card_info_registers.sv
`timescale 1ns/10ps
`default_nettype none
module card_info_registers
    import card_info_pkg::*;
#(
    parameter logic [7:0]  MAKER_CODE   = 8'h5a,            // arbitrary value
    parameter logic [15:0] APP_CODE     = 16'h1234,         // arbitrary value
    parameter logic [47:0] PRODUCT_NAME = 48'h4341_5244_3031,
    parameter logic [7:0]  REVISION     = 8'h10,
    parameter logic [31:0] SERIAL_NUM   = 32'h0000_0001,
    parameter logic [7:0]  MFG_DATE     = 8'h01,
    parameter int          SHORT_GAP_CYCLES = SHORT_GAP_CYC
)
(
    // clock and power-up reset
    input  wire logic              clk,
    input  wire logic              srst,
    // command from the protocol engine
    input  wire logic              cmdValid,
    input  wire cmd_t              cmdCode,
    input  wire logic [ADDR_W-1:0] cmdArg,
    input  wire logic              chipSelectN,
    input  wire logic              powerUpDone,
    // addressed-command matching
    input  wire logic              hostAddrValid,
    input  wire logic [ADDR_W-1:0] hostAddr,
    output logic                   addrHit,
    output logic                   deselectAll,
    // serial readout
    output logic                   serialBit,
    output logic                   serialValid,
    output logic                   serialLast,
    output logic                   cmdRefused,
    output logic                   spiMode,
    // block pacing
    input  wire logic              blockReq,
    input  wire logic [11:0]       blockLen,
    output logic                   blockReady
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        phase_t              phase;      // idle or shifting
        logic [RECORD_W-1:0] shifter;    // word being sent, msb at top
        logic [CNT_W-1:0]    remain;     // bits still to send after current
        logic [ADDR_W-1:0]   relAddr;    // relative card address
        logic                spi;        // SPI mode latched
        logic [15:0]         userBits;   // parameter bits 15:0
        logic [GAP_W-1:0]    gapCount;   // block gap timer
        logic                serialBit;
        logic                serialValid;
        logic                serialLast;
        logic                refused;
        logic                addrHit;
        logic                deselectAll;
        logic                blockReady;
    } state_t;

    state_t stReg;   // registered state
    state_t stNext;  // next state

    // ------------------------------------------------------------
    // identity and record words
    // ------------------------------------------------------------
    id_crc_if crcLink ();                       // checksum carrier
    logic [RECORD_W-1:0] identWord;             // full identity record
    logic [RECORD_W-1:0] paramWord;             // full parameter record
    logic [OPCOND_W-1:0] opcondWord;            // operating conditions
    logic                readCmd;               // decoded read command
    logic                readTake;              // read accepted this cycle
    logic [15:0]         progValue;             // user bits after programming

    // checksum over bits 127:8 of the identity
    assign crcLink.message = {MAKER_CODE, APP_CODE, PRODUCT_NAME, REVISION, SERIAL_NUM, MFG_DATE};

    id_checksum u_crc (
        .link (crcLink.calc)
    );

    // fixed layout, checksum folded in, bit 0 tied high
    assign identWord = {crcLink.message, crcLink.remainder, 1'b1};

    // fixed fields in the top, user bits below
    assign paramWord = {PAR_FIXED, stReg.userBits | USER_FIXED_ONE};

    // ready flag sampled live; the word is factory-fixed otherwise
    assign opcondWord = {powerUpDone, OPCOND_VOLT_RANGE};

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // only the three read commands return a record
    assign readCmd  = (cmdCode == CMD_RD_OPCOND) || (cmdCode == CMD_RD_IDENT)
                    || (cmdCode == CMD_RD_PARAMS);
    assign readTake = cmdValid && readCmd && (stReg.phase == PH_IDLE);

    // copy bit may go 0 to 1 but never back; bit 0 stays one; the rest takes the argument
    assign progValue = ((cmdArg & ~USER_COPY_MASK)
                     | ((cmdArg | stReg.userBits) & USER_COPY_MASK)) | USER_FIXED_ONE;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        stNext             = stReg;
        // pulses default low every cycle
        stNext.refused     = 1'b0;
        stNext.serialValid = 1'b0;
        stNext.serialLast  = 1'b0;
        stNext.blockReady  = 1'b0;
        stNext.addrHit     = 1'b0;
        stNext.deselectAll = 1'b0;

        // serial readout
        case (stReg.phase)
            PH_IDLE:
            begin
                if (readTake)
                begin
                    stNext.phase = PH_SHIFT;
                    // short word sits left-aligned so msb leaves first
                    case (cmdCode)
                        CMD_RD_OPCOND:
                        begin
                            stNext.shifter = {opcondWord, {(RECORD_W-OPCOND_W){1'b0}}};
                            stNext.remain  = OPCOND_LAST;
                        end
                        CMD_RD_IDENT:
                        begin
                            stNext.shifter = identWord;
                            stNext.remain  = RECORD_LAST;
                        end
                        default:
                        begin
                            stNext.shifter = paramWord;
                            stNext.remain  = RECORD_LAST;
                        end
                    endcase
                end
            end
            PH_SHIFT:
            begin
                // one bit per cycle from the top
                stNext.serialBit   = stReg.shifter[RECORD_W-1];
                stNext.serialValid = 1'b1;
                stNext.shifter     = {stReg.shifter[RECORD_W-2:0], 1'b0};
                if (stReg.remain == '0)
                begin
                    stNext.serialLast = 1'b1;
                    stNext.phase      = PH_IDLE;
                end
                else
                begin
                    stNext.remain = stReg.remain - 1'b1;
                end
            end
            default:
            begin
                stNext.phase = PH_IDLE;
            end
        endcase

        // register-changing commands
        if (cmdValid)
        begin
            case (cmdCode)
                CMD_SET_ADDR:
                begin
                    // no address register in SPI mode: refuse
                    if (stReg.spi)
                    begin
                        stNext.refused = 1'b1;
                    end
                    else
                    begin
                        stNext.relAddr = cmdArg;
                    end
                end
                CMD_PROG_PAR:
                begin
                    stNext.userBits = progValue;
                end
                CMD_ERASE_PAR:
                begin
                    // erasable bits clear, copy and lock bits survive
                    stNext.userBits = (stReg.userBits & ~USER_ERASE_MASK) | USER_FIXED_ONE;
                end
                CMD_GO_IDLE:
                begin
                    // mode only ever moves into SPI; leaving needs power cycle
                    if (!chipSelectN)
                    begin
                        stNext.spi = 1'b1;
                    end
                end
                default:
                begin
                    // a read while one is running is dropped
                    if (readCmd && stReg.phase != PH_IDLE)
                    begin
                        stNext.refused = 1'b1;
                    end
                end
            endcase
        end

        // address matching, card bus mode only
        if (hostAddrValid && !stReg.spi)
        begin
            stNext.addrHit     = (hostAddr == stReg.relAddr) && (hostAddr != ADDR_BCAST);
            stNext.deselectAll = (hostAddr == ADDR_BCAST);
        end

        // block pacing timer; a request while running is ignored
        if (stReg.gapCount != '0)
        begin
            stNext.gapCount = stReg.gapCount - 1'b1;
            if (stReg.gapCount == GAP_W'(1))
            begin
                stNext.blockReady = 1'b1;
            end
        end
        else if (blockReq)
        begin
            stNext.gapCount = (blockLen < SHORT_BLOCK_BYTES) ? GAP_W'(SHORT_GAP_CYCLES)
                                                             : GAP_W'(BLOCK_GAP_CYC);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // user bits reset too: no non-volatile cell in this model
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stReg          <= '0;
            stReg.phase    <= PH_IDLE;
            stReg.relAddr  <= ADDR_DEFAULT;
            stReg.userBits <= USER_RESET;
        end
        else
        begin
            stReg <= stNext;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign serialBit   = stReg.serialBit;
    assign serialValid = stReg.serialValid;
    assign serialLast  = stReg.serialLast;
    assign cmdRefused  = stReg.refused;
    assign spiMode     = stReg.spi;
    assign addrHit     = stReg.addrHit;
    assign deselectAll = stReg.deselectAll;
    assign blockReady  = stReg.blockReady;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int GapWait = BLOCK_GAP_CYC;
    // ready shows after the gap's last edge, so it is sampled one edge later
    localparam int GapTail = GapWait - 2;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_ADDR_RESET: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> stReg.relAddr == ADDR_DEFAULT)
        else $error("address not default after reset");
    AST_OPCOND_LEN: assert property (
        (readTake && cmdCode == CMD_RD_OPCOND) |=> ##1 serialValid ##31 serialLast)
        else $error("conditions word length wrong");
    AST_IDENT_MSB: assert property (
        (readTake && cmdCode == CMD_RD_IDENT) |=> ##1 (serialValid && serialBit == identWord[127]))
        else $error("identity not msb first");
    AST_IDENT_TAIL: assert property (
        (readTake && cmdCode == CMD_RD_IDENT) |=> ##128 (serialLast && serialBit))
        else $error("identity last bit not one");
    AST_IDENT_CRC: assert property (
        identWord[7:1] == crcLink.remainder && identWord[0])
        else $error("identity checksum slot wrong");
    AST_SET_ADDR: assert property (
        (cmdValid && cmdCode == CMD_SET_ADDR && !spiMode) |=> stReg.relAddr == $past(cmdArg))
        else $error("address not stored");
    AST_SPI_NO_ADDR: assert property (
        (cmdValid && cmdCode == CMD_SET_ADDR && spiMode) |=> (cmdRefused && $stable(stReg.relAddr)))
        else $error("address written in SPI mode");
    AST_DESELECT: assert property (
        (hostAddrValid && hostAddr == ADDR_BCAST && !spiMode) |=> (deselectAll && !addrHit))
        else $error("zero address not deselect");
    AST_SPI_ENTRY: assert property (
        (cmdValid && cmdCode == CMD_GO_IDLE && !chipSelectN) |=> spiMode [*2])
        else $error("SPI mode not entered");
    AST_COPY_OTP: assert property (
        stReg.userBits[14] |=> stReg.userBits[14])
        else $error("copy bit cleared");
    AST_ERASE: assert property (
        (cmdValid && cmdCode == CMD_ERASE_PAR) |=> ((stReg.userBits & USER_ERASE_MASK) == '0))
        else $error("erase left bits set");
    AST_GAP: assert property (
        (blockReq && stReg.gapCount == '0 && blockLen >= SHORT_BLOCK_BYTES)
        |=> !blockReady [*3] ##GapTail blockReady)
        else $error("block gap wrong");

    COV_IDENT: cover property (readTake && cmdCode == CMD_RD_IDENT ##129 serialLast);
    COV_SET:   cover property (cmdValid && cmdCode == CMD_SET_ADDR ##1 hostAddrValid ##1 addrHit);
    COV_SPI:   cover property (!spiMode ##1 spiMode);
    COV_GAP:   cover property (blockReady);

endmodule
`default_nettype wire

// >>> card_host_rx.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// host side of the serial readout: gathers one record
// ------------------------------------------------------------
module card_host_rx
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // serial stream from the card
    input  wire logic         serialBit,
    input  wire logic         serialValid,
    input  wire logic         serialLast,
    // captured record, bit count, end pulse
    output logic [127:0]      word,
    output logic [7:0]        count,
    output logic              done
);
    logic prevValid; // a rising valid restarts the count
    // shift msb first; word holds still once the burst ends
    always_ff @(posedge clk)
    begin
        prevValid <= serialValid & ~srst;
        done      <= serialValid & serialLast & ~srst;
        if (serialValid)
            word <= {word[126:0], serialBit};
        if (srst)
            count <= 8'h00;
        else if (serialValid)
            count <= prevValid ? count + 8'h01 : 8'h01;
    end
endmodule
`default_nettype wire

// >>> card_info_registers_tb.sv
`timescale 1ns/10ps
`default_nettype none
module card_info_registers_tb;
    import card_info_pkg::*;
    // ------------------------------------------------------------
    // identity contents (maker code arbitrary) and fixed parameter bits
    // ------------------------------------------------------------
    localparam logic [119:0] ID_MSG = {8'h3c, 16'h77a1, 48'h5445_5354_3031, 8'h21, 32'hcafe_0042, 8'h9b};
    localparam logic [111:0] FIXED_EXP = {2'h1, 4'h2, 2'h0, 8'h0e, 8'h01, 8'h2a, 12'h0ff, 4'h9, 4'h8, 2'h0,
        12'h7a7, 3'h5, 3'h4, 3'h5, 3'h4, 3'h3, 5'h00, 5'h0f, 5'h01, 1'b1, 2'h0, 3'h2, 4'h9, 6'h00};
    logic         clk = 1'b0, srst = 1'b1, cmdValid = 1'b0, chipSelectN = 1'b1, powerUpDone = 1'b0;
    logic         hostAddrValid = 1'b0, blockReq = 1'b0, r;
    cmd_t         cmdCode = CMD_NONE;
    logic [15:0]  cmdArg = 16'h0000, hostAddr = 16'h0000, user = 16'h0001, relative_card_address, a;
    logic [11:0]  blockLen = 12'h000;
    logic         addrHit, deselectAll, serialBit, serialValid, serialLast, cmdRefused, spiMode, blockReady, done;
    logic [127:0] word;
    logic [7:0]   count;
    int           bad_count = 0, checks = 0, seed = 32'hd4583df9, i, k;
    always #5 clk = ~clk;
    // short-block gap cut to 20 cycles to keep the run brief
    card_info_registers #(.MAKER_CODE(ID_MSG[119:112]), .APP_CODE(ID_MSG[111:96]), .PRODUCT_NAME(ID_MSG[95:48]),
        .REVISION(ID_MSG[47:40]), .SERIAL_NUM(ID_MSG[39:8]), .MFG_DATE(ID_MSG[7:0]), .SHORT_GAP_CYCLES(20)) uut (
        .clk(clk), .srst(srst), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdArg(cmdArg),
        .chipSelectN(chipSelectN), .powerUpDone(powerUpDone), .hostAddrValid(hostAddrValid),
        .hostAddr(hostAddr), .addrHit(addrHit), .deselectAll(deselectAll), .serialBit(serialBit),
        .serialValid(serialValid), .serialLast(serialLast), .cmdRefused(cmdRefused), .spiMode(spiMode),
        .blockReq(blockReq), .blockLen(blockLen), .blockReady(blockReady));
    card_host_rx rx (.clk(clk), .srst(srst), .serialBit(serialBit), .serialValid(serialValid),
        .serialLast(serialLast), .word(word), .count(count), .done(done));
    // ------------------------------------------------------------
    // expectation helpers and checking
    // ------------------------------------------------------------
    // seven-bit remainder of msg * x^7 over x^7 + x^3 + 1
    function automatic logic [6:0] crc7(input logic [119:0] m);
        logic [6:0] c;
        c = 7'h00;
        for (int j = 119; j >= 0; j--)
            c = {c[5:0], 1'b0} ^ ((m[j] ^ c[6]) ? 7'h09 : 7'h00);
        return c;
    endfunction
    task automatic chk(input string n, input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // port drivers
    // ------------------------------------------------------------
    // one-cycle command strobe; r collects a refusal over two cycles
    task automatic cmd(input cmd_t c, input logic [15:0] v);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdCode  <= c;
        cmdArg   <= v;
        @(posedge clk);
        cmdValid <= 1'b0;
        r = 1'b0;
        repeat (2)
        begin
            #1 r = r | cmdRefused;
            @(posedge clk);
        end
    endtask
    // wait for a record burst, compare its length and its low n bits
    task automatic fetch(input int n, input logic [127:0] exp);
        for (i = 0; i < 300 && done !== 1'b1; i++)
            @(posedge clk);
        if (i == 300)
        begin
            bad_count++;
            tally_and_finish();
        end
        else
        begin
            chk("bit count", count, n[7:0]);
            chk("record", word << (128 - n), exp << (128 - n));
        end
    endtask
    task automatic rd(input cmd_t c, input int n, input logic [127:0] exp);
        cmd(c, 16'h0000);
        chk("refused", r, 1'b0);
        fetch(n, exp);
    endtask
    task automatic hit(input logic [15:0] v, input logic eh, input logic ed);
        logic h, d;
        @(posedge clk);
        hostAddrValid <= 1'b1;
        hostAddr      <= v;
        @(posedge clk);
        hostAddrValid <= 1'b0;
        h = 1'b0;
        d = 1'b0;
        repeat (2)
        begin
            #1 h = h | addrHit;
            d = d | deselectAll;
            @(posedge clk);
        end
        chk("addrHit", h, eh);
        chk("deselectAll", d, ed);
    endtask
    // gap must end exactly n cycles after the taking edge
    task automatic blk(input logic [11:0] len, input int n);
        @(posedge clk);
        blockReq <= 1'b1;
        blockLen <= len;
        @(posedge clk);
        blockReq <= 1'b0;
        // look just after each edge so i counts edges since the taking edge
        for (i = 0; i < 300 && blockReady !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (i == 300)
        begin
            bad_count++;
            tally_and_finish();
        end
        else
            chk("gap", i, n);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        hit(16'h0001, 1'b1, 1'b0);
        rd(CMD_RD_IDENT, 128, {ID_MSG, crc7(ID_MSG), 1'b1});
        for (k = 0; k < 2; k++)
        begin
            powerUpDone <= k[0];
            rd(CMD_RD_OPCOND, 32, {96'h0, k[0], OPCOND_VOLT_RANGE});
        end
        rd(CMD_RD_PARAMS, 128, {FIXED_EXP, user});
        cmd(CMD_RD_IDENT, 16'h0000);
        cmd(CMD_RD_PARAMS, 16'h0000);
        chk("read while shifting", r, 1'b1);
        fetch(128, {ID_MSG, crc7(ID_MSG), 1'b1});
        $display("test readout done");
        for (k = 0; k < 4; k++)
        begin
            relative_card_address = 16'($random(seed));
            relative_card_address = (relative_card_address == 16'h0000) ? 16'h0001 : relative_card_address;
            cmd(CMD_SET_ADDR, relative_card_address);
            hit(relative_card_address, 1'b1, 1'b0);
            hit(relative_card_address ^ 16'h0100, 1'b0, relative_card_address == 16'h0100);
            hit(16'h0000, 1'b0, 1'b1);
        end
        $display("test address done");
        for (k = 0; k < 4; k++)
        begin
            a = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
            cmd(CMD_PROG_PAR, a);
            user = {a[15], user[14] | a[14], a[13:1], 1'b1};
            rd(CMD_RD_PARAMS, 128, {FIXED_EXP, user});
        end
        cmd(CMD_ERASE_PAR, 16'h0000);
        user = user & ~16'h13fe;
        rd(CMD_RD_PARAMS, 128, {FIXED_EXP, user});
        $display("test user bits done");
        blk(12'h100, 100);
        blk(12'h0ff, 20);
        blk(12'h001, 20);
        $display("test block gap done");
        chipSelectN <= 1'b0;
        cmd(CMD_GO_IDLE, 16'h0000);
        chipSelectN <= 1'b1;
        chk("spiMode", spiMode, 1'b1);
        cmd(CMD_SET_ADDR, 16'h1234);
        chk("address in spi", r, 1'b1);
        hit(relative_card_address, 1'b0, 1'b0);
        rd(CMD_RD_PARAMS, 128, {FIXED_EXP, user});
        $display("test spi done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
